// file: shared/so_decl_map.vh
// Purpose: Constants for the stream-out declaration entry decoder
// Assumes: APB byte addresses, 32-bit data, one word per register
// Notes: Offsets are plain byte addresses
`ifndef SO_DECL_MAP_VH
`define SO_DECL_MAP_VH

// Declaration entry fields
`define ENT_BUF_HI 13
`define ENT_BUF_LO 12
`define ENT_HOLE_BIT 11
`define ENT_ROW_HI 9
`define ENT_ROW_LO 4
`define ENT_MASK_HI 3
`define ENT_MASK_LO 0

// Register byte offsets
`define REG_CTRL 12'h000
`define REG_RDOFS 12'h004
`define REG_STAT 12'h008
`define REG_WPOS0 12'h010
`define REG_WPOS1 12'h014
`define REG_WPOS2 12'h018
`define REG_WPOS3 12'h01C

// Control fields and reset values
`define CTRL_EN_BIT 0
`define CTRL_CLR_BIT 1
`define CTRL_RST 1'h0
`define RDOFS_RST 6'h00
`define WPOS_RST 32'h0000_0000

// State codes
`define ST_IDLE 3'h0
`define ST_DEC 3'h1
`define ST_RD 3'h2
`define ST_WR 3'h3

`endif

// file: design/decl_split.v
// Purpose: Splits one declaration entry into its fields
// Assumes: Lane-select mask in the low nibble
// Notes: Purely combinational
`timescale 1ns/10ps
`include "so_decl_map.vh"

module decl_split (
  input wire [15:0] entry,
  output wire [1:0] buf_sel,
  output wire hole,
  output wire [5:0] row,
  output wire [3:0] mask,
  output wire [2:0] words
);

  function [2:0] lane_count;
    input [3:0] m;
    begin
      lane_count = {2'b00, m[0]} + {2'b00, m[1]} +
        {2'b00, m[2]} + {2'b00, m[3]};
    end
  endfunction

  assign buf_sel = entry[`ENT_BUF_HI:`ENT_BUF_LO];
  assign hole = entry[`ENT_HOLE_BIT];
  assign row = entry[`ENT_ROW_HI:`ENT_ROW_LO];
  assign mask = entry[`ENT_MASK_HI:`ENT_MASK_LO];
  // Contiguous hole masks count the same as written lanes
  assign words = lane_count(mask);

endmodule // decl_split

// file: design/lane_pick.v
// Purpose: Picks the lowest enabled, not yet written lane of a row
// Assumes: Row is four 32-bit lanes, lane 0 in the low bits
// Notes: Combinational
`timescale 1ns/10ps

module lane_pick (
  input wire [3:0] mask,
  input wire [3:0] done,
  input wire [127:0] row_data,
  output reg any,
  output reg [1:0] lane,
  output wire [31:0] word
);

  wire [31:0] slice [0:3];
  wire [3:0] left;
  integer i;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_slice
      assign slice[g] = row_data[32*g+31:32*g];
    end
  endgenerate

  assign left = mask & ~done;

  always @* begin
    any = 1'b0;
    lane = 2'b00;
    for (i = 3; i >= 0; i = i - 1) begin
      if (left[i]) begin
        any = 1'b1;
        lane = i[1:0];
      end
    end
  end

  assign word = slice[lane];

endmodule // lane_pick

// file: design/stream_out_decl_decoder.v
// Purpose: Executes stream-out declaration entries in list order
// Assumes: Entry source, vertex store and buffer writer share CLK
// Notes: Registers reached over APB; one entry in flight at a time
`timescale 1ns/10ps
`include "so_decl_map.vh"

module stream_out_decl_decoder (
  input wire CLK,
  input wire NRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire ENTRY_VALID,
  input wire [15:0] ENTRY_DATA,
  output reg ENTRY_READY,
  output reg VTX_RD_REQ,
  output reg [6:0] VTX_RD_ROW,
  input wire VTX_RD_VALID,
  input wire [127:0] VTX_RD_DATA,
  output reg BUF_WR_VALID,
  output reg [1:0] BUF_WR_SEL,
  output reg [31:0] BUF_WR_ADDR,
  output reg [31:0] BUF_WR_DATA,
  input wire BUF_WR_READY,
  output reg BUSY
);

  reg [2:0] state_q;
  reg [15:0] entry_q;
  reg [127:0] row_q;
  reg [3:0] done_q;
  reg en_q;
  reg [5:0] rdofs_q;
  reg [15:0] ent_cnt_q;
  reg [15:0] hole_cnt_q;
  reg [31:0] wpos_q [0:3];
  reg [31:0] wpos_d [0:3];
  reg [31:0] rd_d;
  reg err_d;

  wire [1:0] buf_sel;
  wire hole;
  wire [5:0] row_idx;
  wire [3:0] mask;
  wire [2:0] words;
  wire any;
  wire [1:0] lane;
  wire [31:0] word;
  wire apb_acc;
  wire apb_wr;
  wire take;
  wire wr_done;
  wire skip_like;

  decl_split u_split (
    .entry(entry_q),
    .buf_sel(buf_sel),
    .hole(hole),
    .row(row_idx),
    .mask(mask),
    .words(words)
  );

  lane_pick u_pick (
    .mask(mask),
    .done(done_q),
    .row_data(row_q),
    .any(any),
    .lane(lane),
    .word(word)
  );

  assign apb_acc = PSEL & PENABLE & ~PREADY;
  // Write lands on the edge that completes the access, with PREADY high
  assign apb_wr = PSEL & PENABLE & PREADY & PWRITE;
  assign take = ENTRY_VALID & ENTRY_READY;
  assign wr_done = BUF_WR_VALID & BUF_WR_READY;
  // Empty write masks behave like no-operation holes
  assign skip_like = hole | (mask == 4'h0);

  // Slave answers in the second access cycle
  always @(posedge CLK) begin
    if (!NRST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= apb_acc;
      PRDATA <= (apb_acc & ~PWRITE) ? rd_d : 32'h0000_0000;
      PSLVERR <= apb_acc & err_d;
    end
  end

  always @* begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    case (PADDR)
      `REG_CTRL: rd_d = {31'h0000_0000, en_q};
      `REG_RDOFS: rd_d = {26'h000_0000, rdofs_q};
      `REG_STAT: rd_d = {hole_cnt_q[14:0], ent_cnt_q, BUSY};
      `REG_WPOS0: rd_d = wpos_q[0];
      `REG_WPOS1: rd_d = wpos_q[1];
      `REG_WPOS2: rd_d = wpos_q[2];
      `REG_WPOS3: rd_d = wpos_q[3];
      default: err_d = 1'b1;
    endcase
  end

  always @(posedge CLK) begin
    if (!NRST) begin
      en_q <= `CTRL_RST;
      rdofs_q <= `RDOFS_RST;
    end else if (apb_wr) begin
      if (PADDR == `REG_CTRL) begin
        en_q <= PWDATA[`CTRL_EN_BIT];
      end
      if (PADDR == `REG_RDOFS) begin
        rdofs_q <= PWDATA[5:0];
      end
    end
  end

  // Position update; hardware advance wins over a software write
  integer k;
  integer m;
  always @* begin
    for (k = 0; k < 4; k = k + 1) begin
      wpos_d[k] = wpos_q[k];
      if (apb_wr && PADDR == (`REG_WPOS0 + k[11:0] * 12'h004)) begin
        wpos_d[k] = PWDATA;
      end
      if (apb_wr && PADDR == `REG_CTRL && PWDATA[`CTRL_CLR_BIT]) begin
        wpos_d[k] = `WPOS_RST;
      end
    end
    if (state_q == `ST_DEC && skip_like) begin
      wpos_d[buf_sel] = wpos_q[buf_sel] + {29'h0000_0000, words};
    end
    if (state_q == `ST_WR && wr_done) begin
      wpos_d[buf_sel] = wpos_q[buf_sel] + 32'h0000_0001;
    end
  end

  always @(posedge CLK) begin
    if (!NRST) begin
      for (m = 0; m < 4; m = m + 1) begin
        wpos_q[m] <= `WPOS_RST;
      end
    end else begin
      for (m = 0; m < 4; m = m + 1) begin
        wpos_q[m] <= wpos_d[m];
      end
    end
  end

  // Entry sequencer; one entry fully retires before the next is taken
  always @(posedge CLK) begin
    if (!NRST) begin
      state_q <= `ST_IDLE;
      entry_q <= 16'h0000;
      row_q <= 128'h0;
      done_q <= 4'h0;
      ENTRY_READY <= 1'b0;
      VTX_RD_REQ <= 1'b0;
      VTX_RD_ROW <= 7'h00;
      BUF_WR_VALID <= 1'b0;
      BUF_WR_SEL <= 2'b00;
      BUF_WR_ADDR <= 32'h0000_0000;
      BUF_WR_DATA <= 32'h0000_0000;
      BUSY <= 1'b0;
      ent_cnt_q <= 16'h0000;
      hole_cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        `ST_IDLE: begin
          if (take) begin
            entry_q <= ENTRY_DATA;
            ENTRY_READY <= 1'b0;
            BUSY <= 1'b1;
            state_q <= `ST_DEC;
          end else begin
            ENTRY_READY <= en_q;
          end
        end
        `ST_DEC: begin
          ent_cnt_q <= ent_cnt_q + 16'h0001;
          done_q <= 4'h0;
          if (skip_like) begin
            // No write is issued for skipped words
            hole_cnt_q <= hole_cnt_q + 16'h0001;
            BUSY <= 1'b0;
            state_q <= `ST_IDLE;
          end else begin
            VTX_RD_REQ <= 1'b1;
            VTX_RD_ROW <= {1'b0, rdofs_q} + {1'b0, row_idx};
            state_q <= `ST_RD;
          end
        end
        `ST_RD: begin
          if (VTX_RD_VALID) begin
            row_q <= VTX_RD_DATA;
            VTX_RD_REQ <= 1'b0;
            state_q <= `ST_WR;
          end
        end
        `ST_WR: begin
          if (BUF_WR_VALID) begin
            if (BUF_WR_READY) begin
              BUF_WR_VALID <= 1'b0;
              done_q[lane] <= 1'b1;
            end
          end else if (any) begin
            // Set lanes pack into consecutive words
            BUF_WR_VALID <= 1'b1;
            BUF_WR_SEL <= buf_sel;
            BUF_WR_ADDR <= wpos_q[buf_sel];
            BUF_WR_DATA <= word;
          end else begin
            BUSY <= 1'b0;
            state_q <= `ST_IDLE;
          end
        end
        default: begin
          state_q <= `ST_IDLE;
          ENTRY_READY <= 1'b0;
          VTX_RD_REQ <= 1'b0;
          BUF_WR_VALID <= 1'b0;
          BUSY <= 1'b0;
        end
      endcase
    end
  end

endmodule // stream_out_decl_decoder

// file: tb/decl_chk_assertions.sv
// Purpose: Port checks for the decoder
// Assumes: One clock domain
// Notes: Bound below
`timescale 1ns/10ps
module decl_chk (
  input wire CLK,
  input wire NRST,
  input wire ENTRY_VALID,
  input wire [15:0] ENTRY_DATA,
  input wire ENTRY_READY,
  input wire VTX_RD_REQ,
  input wire BUF_WR_VALID,
  input wire [1:0] BUF_WR_SEL,
  input wire [31:0] BUF_WR_ADDR,
  input wire BUF_WR_READY,
  input wire BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic [1:0] sel_q;
  wire tk = ENTRY_VALID && ENTRY_READY;
  wire hl = tk && ENTRY_DATA[11];
  wire ac = BUF_WR_VALID && BUF_WR_READY;
  always_ff @(posedge CLK) begin
    if (!NRST)
      sel_q <= 2'h0;
    else if (tk)
      sel_q <= ENTRY_DATA[13:12];
  end
  a_hole_no_rd: assert property (hl |-> !VTX_RD_REQ [*4])
    else $error("skip read");
  a_hole_no_wr: assert property (hl |-> !BUF_WR_VALID [*4])
    else $error("skip write");
  a_hole_done: assert property (hl |-> ##[2:4] ENTRY_READY)
    else $error("skip stuck");
  a_rd_start: assert property (
    tk && !ENTRY_DATA[11] && ENTRY_DATA[3:0] != 4'h0 |-> ##[1:3] VTX_RD_REQ)
    else $error("no read");
  a_wr_hold: assert property (BUF_WR_VALID && !BUF_WR_READY |=>
    BUF_WR_VALID && $stable({BUF_WR_SEL, BUF_WR_ADDR}))
    else $error("write moved");
  a_wr_sel: assert property (BUF_WR_VALID |-> BUF_WR_SEL == sel_q)
    else $error("wrong buffer");
  // Next word of one entry lands on the following position
  a_wr_step: assert property (ac |=> !BUF_WR_VALID ##1
    (!BUF_WR_VALID || BUF_WR_ADDR == $past(BUF_WR_ADDR, 2) + 32'h1))
    else $error("address step");
  a_one_entry: assert property (tk |=> BUSY && !ENTRY_READY)
    else $error("second entry");
  cover property (hl);
  cover property (ac);
  cover property (VTX_RD_REQ);
endmodule // decl_chk

bind stream_out_decl_decoder decl_chk u_chk (.CLK, .NRST, .ENTRY_VALID,
  .ENTRY_DATA, .ENTRY_READY, .VTX_RD_REQ, .BUF_WR_VALID, .BUF_WR_SEL,
  .BUF_WR_ADDR, .BUF_WR_READY, .BUSY);

// file: tb/far_side.sv
// Purpose: Vertex store and buffer writer model
// Assumes: Shares CLK with the decoder
// Notes: slow adds wait cycles
`timescale 1ns/10ps
module far_side (
  input wire CLK,
  input wire NRST,
  input wire slow,
  input wire req,
  input wire [6:0] row,
  input wire wv,
  output logic rv,
  output logic [127:0] rdat,
  output logic wr
);
  logic [2:0] n;
  wire go = NRST && req && !rv && n >= {slow, 2'h0};
  always @(posedge CLK) begin
    n <= (req && !rv) || (wv && !wr) ? n + 3'h1 : 3'h0;
    rv <= go;
    wr <= NRST && wv && !wr && n >= {1'b0, slow, 1'b0};
    // Outside the strobe the row is inverted, never left stale
    for (int l = 0; l < 4; l++)
      rdat[32 * l +: 32] <= {8'hC0, 1'b0, row, 14'h0, 2'(l)} ^ {32{!go}};
  end
endmodule // far_side

// file: tb/stream_out_decl_decoder_tb.sv
// Purpose: Decoder bench
// Assumes: Far side modelled in far_side
// Notes: Writes checked against a queue
`timescale 1ns/10ps
`include "so_decl_map.vh"
module stream_out_decl_decoder_tb;
  logic CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, slow, err;
  logic ENTRY_VALID, ENTRY_READY, VTX_RD_REQ, VTX_RD_VALID, BUSY;
  logic BUF_WR_VALID, BUF_WR_READY;
  logic [1:0] BUF_WR_SEL;
  logic [6:0] VTX_RD_ROW;
  logic [11:0] PADDR;
  logic [15:0] ENTRY_DATA;
  logic [31:0] PWDATA, PRDATA, BUF_WR_ADDR, BUF_WR_DATA, rd;
  logic [127:0] VTX_RD_DATA;
  logic [65:0] exq[$];
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  stream_out_decl_decoder uut (.CLK, .NRST, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .ENTRY_VALID, .ENTRY_DATA,
    .ENTRY_READY, .VTX_RD_REQ, .VTX_RD_ROW, .VTX_RD_VALID, .VTX_RD_DATA,
    .BUF_WR_VALID, .BUF_WR_SEL, .BUF_WR_ADDR, .BUF_WR_DATA, .BUF_WR_READY,
    .BUSY);
  far_side fs (.CLK(CLK), .NRST(NRST), .slow(slow), .req(VTX_RD_REQ),
    .row(VTX_RD_ROW), .wv(BUF_WR_VALID), .rv(VTX_RD_VALID),
    .rdat(VTX_RD_DATA), .wr(BUF_WR_READY));
  task chk(input logic [65:0] g, e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
    @(posedge CLK) PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    {PSEL, PENABLE} <= 2'h0;
    @(posedge CLK);
  endtask
  // Returns only once the entry has retired
  task ent(input logic [15:0] e);
    {ENTRY_VALID, ENTRY_DATA} <= {1'b1, e};
    do @(posedge CLK); while (ENTRY_READY !== 1'b1);
    {ENTRY_VALID, ENTRY_DATA} <= {1'b0, ~e};
    do @(posedge CLK); while (ENTRY_READY !== 1'b1);
  endtask
  task results;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    if (++cyc == 3000) begin
      error_cnt++;
      results;
    end
    if (BUF_WR_VALID && BUF_WR_READY) begin
      if (exq.size() == 0)
        chk(66'h1, 66'h0);
      else
        chk({BUF_WR_SEL, BUF_WR_ADDR, BUF_WR_DATA}, exq.pop_front());
    end
  end
  initial begin
    {NRST, PSEL, PENABLE, PWRITE, ENTRY_VALID, slow} = 6'h0;
    {PADDR, PWDATA, ENTRY_DATA} = 60'h0;
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    apb(1'b0, `REG_WPOS0, 32'h0);
    chk(rd, `WPOS_RST);
    apb(1'b1, 12'h00C, 32'h0000_00FF);
    chk(err, 1'b1);
    apb(1'b1, `REG_RDOFS, 32'h2);
    apb(1'b1, `REG_CTRL, 32'h1);
    ent(16'h0000);
    exq.push_back({2'h1, 32'h0, 32'hC005_0001});
    exq.push_back({2'h1, 32'h1, 32'hC005_0003});
    ent(16'h103A);
    for (int i = 0; i < 4; i++)
      ent({12'h2BF, 4'hF >> (3 - i)});
    apb(1'b0, `REG_WPOS2, 32'h0);
    chk(rd, 32'hA);
    ent(16'h3800);
    apb(1'b0, `REG_WPOS3, 32'h0);
    chk(rd, 32'h0);
    slow <= 1'b1;
    for (int l = 0; l < 4; l++)
      exq.push_back({2'h2, 32'(10 + l), 16'hC002, 16'(l)});
    ent(16'h200F);
    apb(1'b0, `REG_WPOS2, 32'h0);
    chk(rd, 32'hE);
    apb(1'b0, `REG_STAT, 32'h0);
    chk(rd, 32'h000C_0010);
    apb(1'b1, `REG_CTRL, 32'h3);
    apb(1'b0, `REG_WPOS1, 32'h0);
    chk(rd, `WPOS_RST);
    chk(exq.size(), 0);
    results;
  end
endmodule // stream_out_decl_decoder_tb
